//--- pkg/tmhp_pkg.sv
package tmhp_pkg;

  localparam int DATA_W = 16;
  localparam int BYTE_W = 8;
  localparam int PTR_W = 5;
  localparam int DEPTH = 32;
  localparam int COUNTERS = 5;
  localparam int SYNC_STAGES = 3;

  // Data pointer layout: element in [4:3], group in [2:0]
  localparam logic [PTR_W-1:0] PTR_RESET = 5'h01;
  localparam logic [PTR_W-1:0] MASTER_MODE_INDEX = 5'h17;
  localparam logic [PTR_W-1:0] STATUS_INDEX = 5'h1F;

  // Commands with these top bits zero load the data pointer
  localparam int CMD_CLASS_LSB = 5;
  localparam logic [2:0] CMD_LOAD_POINTER = 3'h0;

  localparam int WIDTH_SELECT_BIT = 14;
  localparam logic [DATA_W-1:0] MASTER_MODE_RESET = 16'h0000;
  localparam logic [BYTE_W-1:0] COMMAND_RESET = 8'h00;
  localparam int AUX_GATE_LSB = 8;
  localparam logic [COUNTERS-1:0] GATES_ENABLED = 5'h1F;
  localparam logic [DATA_W-1:0] OE_ALL_OFF = 16'hFFFF;
  localparam logic [DATA_W-1:0] OE_LOW_BYTE = 16'hFF00;

  typedef enum logic [2:0] {
    TMHP_IDLE  = 3'b001,
    TMHP_READ  = 3'b010,
    TMHP_WRITE = 3'b100
  } tmhp_access_e;

  typedef struct packed {
    logic cs_n;
    logic rd_n;
    logic wr_n;
    logic ctrl;
    logic [DATA_W-1:0] data;
  } tmhp_pins_s;

  localparam int PINS_W = $bits(tmhp_pins_s);
  localparam logic [PINS_W-1:0] PINS_IDLE = {3'h7, 1'b0, 16'h0000};

endpackage

//--- hw/tmhp_regfile.sv
`timescale 1ns/1ps
module tmhp_regfile
  import tmhp_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [PTR_W-1:0] addr,
  input wire logic [1:0] byte_we,
  input wire logic [DATA_W-1:0] wdata,
  output logic [DATA_W-1:0] rdata
);

  // Contents are undefined until software loads them
  // One array per byte lane, so each has a single writer
  genvar i;
  generate
    for (i = 0; i < 2; i++) begin : g_lane
      logic [BYTE_W-1:0] lane [DEPTH];
      logic [BYTE_W-1:0] lane_q;
      always_ff @(posedge clock) begin
        if (byte_we[i]) begin
          lane[addr] <= wdata[i*BYTE_W +: BYTE_W];
        end
      end
      always_ff @(posedge clock) begin
        if (!rst_n) begin
          lane_q <= '0;
        end else begin
          lane_q <= lane[addr];
        end
      end
      assign rdata[i*BYTE_W +: BYTE_W] = lane_q;
    end
  endgenerate

endmodule

//--- hw/tmhp_port.sv
`timescale 1ns/1ps
// Function
// - Chip select plus read drives selected value
// - Chip select plus write captures bus value
// - Data reads selected by data pointer
// - Data writes steered by data pointer
// - Control write loads command, and pointer if bits 7:5 are zero
// - Control read returns status
// - Data port reaches all other registers
// - Reset selects 8-bit bus width
// - 8-bit mode: lines 8-12 gate counters
module tmhp_port
  import tmhp_pkg::*;
(
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire logic CS_N,
  input wire logic RD_N,
  input wire logic WR_N,
  input wire logic CTRL_SEL,
  input wire logic [DATA_W-1:0] HOST_DATA_LINES_IN,
  output logic [DATA_W-1:0] HOST_DATA_LINES_OUT,
  output logic [DATA_W-1:0] HOST_DATA_LINES_OE_N,
  input wire logic [DATA_W-1:0] STATUS,
  output logic [BYTE_W-1:0] COMMAND,
  output logic COMMAND_STROBE,
  output logic [PTR_W-1:0] DATA_POINTER,
  output logic [DATA_W-1:0] MASTER_MODE,
  output logic BUS_WIDTH_SELECT,
  output logic [COUNTERS-1:0] AUX_GATE_ENABLE_N
);

  tmhp_pins_s pins_raw;
  logic [PINS_W-1:0] sync1;
  logic [PINS_W-1:0] sync2;
  logic [PINS_W-1:0] sync3;
  logic [PINS_W-1:0] pins_flat;
  tmhp_pins_s pins;
  tmhp_access_e state;
  tmhp_access_e next_state;
  logic byte_sel;
  logic wide;
  logic entering_write;
  logic leaving_data;
  logic access_is_data;
  logic [DATA_W-1:0] next_mode;
  logic [1:0] byte_we;
  logic [DATA_W-1:0] wdata;
  logic [DATA_W-1:0] mem_rdata;
  logic [DATA_W-1:0] word;
  logic [DATA_W-1:0] next_out;

  assign pins_raw = '{cs_n: CS_N, rd_n: RD_N, wr_n: WR_N, ctrl: CTRL_SEL,
                      data: HOST_DATA_LINES_IN};

  // Three stages; a bit moves only when stages two and three agree
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      sync1 <= PINS_IDLE;
      sync2 <= PINS_IDLE;
      sync3 <= PINS_IDLE;
    end else begin
      sync1 <= pins_raw;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  genvar b;
  generate
    for (b = 0; b < PINS_W; b++) begin : g_filter
      always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
          pins_flat[b] <= PINS_IDLE[b];
        end else if (sync2[b] == sync3[b]) begin
          pins_flat[b] <= sync3[b];
        end
      end
    end
  endgenerate

  assign pins = pins_flat;
  assign wide = MASTER_MODE[WIDTH_SELECT_BIT];
  assign BUS_WIDTH_SELECT = wide;

  // Overlapping strobes are treated as no access
  always_comb begin
    next_state = TMHP_IDLE;
    if (!pins.cs_n && !pins.rd_n && pins.wr_n) begin
      next_state = TMHP_READ;
    end else if (!pins.cs_n && !pins.wr_n && pins.rd_n) begin
      next_state = TMHP_WRITE;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      state <= TMHP_IDLE;
    end else begin
      state <= next_state;
    end
  end

  assign entering_write = (next_state == TMHP_WRITE) && (state != TMHP_WRITE);
  // Port kind held from access start; ctrl drops with the strobe
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      access_is_data <= 1'b0;
    end else if (state == TMHP_IDLE && next_state != TMHP_IDLE) begin
      access_is_data <= !pins.ctrl;
    end
  end

  assign leaving_data = (state != TMHP_IDLE) && (next_state != state) &&
                        access_is_data;

  // Command register loads on a control write; pointer when bits 7:5 are zero
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      COMMAND <= COMMAND_RESET;
      COMMAND_STROBE <= 1'b0;
      DATA_POINTER <= PTR_RESET;
    end else begin
      COMMAND_STROBE <= 1'b0;
      if (entering_write && pins.ctrl) begin
        COMMAND <= pins.data[BYTE_W-1:0];
        COMMAND_STROBE <= 1'b1;
        if (pins.data[BYTE_W-1:CMD_CLASS_LSB] == CMD_LOAD_POINTER) begin
          DATA_POINTER <= pins.data[PTR_W-1:0];
        end
      end
    end
  end

  // Byte selector restarts on the low byte after any control write
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      byte_sel <= 1'b0;
    end else if (entering_write && pins.ctrl) begin
      byte_sel <= 1'b0;
    end else if (leaving_data && !wide) begin
      byte_sel <= ~byte_sel;
    end
  end

  // Data-port write lanes; the status slot is read only
  always_comb begin
    byte_we = 2'b00;
    wdata = pins.data;
    if (entering_write && !pins.ctrl && DATA_POINTER != STATUS_INDEX) begin
      if (wide) begin
        byte_we = 2'b11;
      end else begin
        wdata = {pins.data[BYTE_W-1:0], pins.data[BYTE_W-1:0]};
        byte_we = byte_sel ? 2'b10 : 2'b01;
      end
    end
  end

  tmhp_regfile u_regfile (
    .clock(CLOCK),
    .rst_n(RST_N),
    .addr(DATA_POINTER),
    .byte_we(byte_we),
    .wdata(wdata),
    .rdata(mem_rdata)
  );

  // Next mode, so width and gate use switch on one edge
  always_comb begin
    next_mode = MASTER_MODE;
    if (DATA_POINTER == MASTER_MODE_INDEX) begin
      if (byte_we[0]) begin
        next_mode[BYTE_W-1:0] = wdata[BYTE_W-1:0];
      end
      if (byte_we[1]) begin
        next_mode[DATA_W-1:BYTE_W] = wdata[DATA_W-1:BYTE_W];
      end
    end
  end

  // Shadow kept so width and options act without a memory read
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      MASTER_MODE <= MASTER_MODE_RESET;
    end else begin
      MASTER_MODE <= next_mode;
    end
  end

  // Read source selection
  always_comb begin
    if (pins.ctrl) begin
      word = STATUS;
    end else if (DATA_POINTER == STATUS_INDEX) begin
      word = STATUS;
    end else if (DATA_POINTER == MASTER_MODE_INDEX) begin
      word = MASTER_MODE;
    end else begin
      word = mem_rdata;
    end
    if (wide) begin
      next_out = word;
    end else if (byte_sel && !pins.ctrl) begin
      next_out = {8'h00, word[DATA_W-1:BYTE_W]};
    end else begin
      next_out = {8'h00, word[BYTE_W-1:0]};
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      HOST_DATA_LINES_OUT <= '0;
      HOST_DATA_LINES_OE_N <= OE_ALL_OFF;
    end else begin
      HOST_DATA_LINES_OUT <= next_out;
      if (next_state == TMHP_READ) begin
        HOST_DATA_LINES_OE_N <= wide ? '0 : OE_LOW_BYTE;
      end else begin
        HOST_DATA_LINES_OE_N <= OE_ALL_OFF;
      end
    end
  end

  // Upper lines are host inputs in narrow mode; 13-15 are not looked at
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      AUX_GATE_ENABLE_N <= GATES_ENABLED;
    end else if (next_mode[WIDTH_SELECT_BIT]) begin
      AUX_GATE_ENABLE_N <= GATES_ENABLED;
    end else begin
      AUX_GATE_ENABLE_N <= pins.data[AUX_GATE_LSB +: COUNTERS];
    end
  end

endmodule

//--- bench/tmhp_port_assertions.sv
`timescale 1ns/1ps
module tmhp_port_assertions
  import tmhp_pkg::*;
(
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire logic CS_N,
  input wire logic RD_N,
  input wire logic WR_N,
  input wire logic CTRL_SEL,
  input wire logic [DATA_W-1:0] HOST_DATA_LINES_OUT,
  input wire logic [DATA_W-1:0] HOST_DATA_LINES_OE_N,
  input wire logic [BYTE_W-1:0] COMMAND,
  input wire logic COMMAND_STROBE,
  input wire logic [PTR_W-1:0] DATA_POINTER,
  input wire logic BUS_WIDTH_SELECT,
  input wire logic [COUNTERS-1:0] AUX_GATE_ENABLE_N
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_N);
  sequence s_read;
    !CS_N && !RD_N && WR_N;
  endsequence
  sequence s_load;
    COMMAND_STROBE && COMMAND[7:5] == CMD_LOAD_POINTER;
  endsequence
  // Seven samples leave room for the pin synchroniser
  property p_drive;
    s_read [*7] |-> HOST_DATA_LINES_OE_N[7:0] == 8'h00;
  endproperty
  a_drive: assert property (p_drive) else $error("no drive");
  property p_float;
    CS_N [*8] |-> HOST_DATA_LINES_OE_N == OE_ALL_OFF;
  endproperty
  a_float: assert property (p_float) else $error("not floating");
  property p_src;
    COMMAND_STROBE |-> !$past(CS_N, 2) && !$past(WR_N, 2)
      && $past(CTRL_SEL, 2);
  endproperty
  a_src: assert property (p_src) else $error("bad strobe");
  property p_pulse;
    COMMAND_STROBE |=> !COMMAND_STROBE;
  endproperty
  a_pulse: assert property (p_pulse) else $error("long strobe");
  property p_pointer;
    s_load |-> DATA_POINTER == COMMAND[4:0];
  endproperty
  a_pointer: assert property (p_pointer) else $error("ptr");
  property p_narrow;
    !BUS_WIDTH_SELECT |-> HOST_DATA_LINES_OE_N[15:8] == 8'hFF
      && HOST_DATA_LINES_OUT[15:8] == 8'h00;
  endproperty
  a_narrow: assert property (p_narrow) else $error("upper");
  property p_gates;
    BUS_WIDTH_SELECT |-> AUX_GATE_ENABLE_N == GATES_ENABLED;
  endproperty
  a_gates: assert property (p_gates) else $error("gates");
  property p_reset;
    !$past(RST_N) |-> DATA_POINTER == PTR_RESET && !BUS_WIDTH_SELECT;
  endproperty
  a_reset: assert property (p_reset) else $error("reset");
endmodule
bind tmhp_port tmhp_port_assertions chk_i (.*);

//--- bench/tmhp_host.sv
`timescale 1ns/1ps
module tmhp_host
  import tmhp_pkg::*;
(
  input wire logic clk,
  input wire logic [DATA_W-1:0] dout,
  input wire logic [DATA_W-1:0] oe_n,
  output tmhp_pins_s pins
);
  tmhp_pins_s p = PINS_IDLE;
  logic [DATA_W-1:0] drv = 16'hFFFF;
  logic [COUNTERS-1:0] gates = 5'h1F;
  logic wide = 1'b0;
  // Idle lines toggle so a stale value never reads as valid
  always @(posedge clk) if (p.wr_n) drv <= ~drv;
  always_comb begin
    pins = p;
    for (int i = 0; i < DATA_W; i++)
      pins.data[i] = !oe_n[i] ? dout[i] : drv[i];
    if (!wide) pins.data[12:8] = gates;
    if (!wide && !p.wr_n) pins.data[15:13] = 3'h7;
  end
  task automatic acc(input logic off, input logic c, input logic w,
    input logic [DATA_W-1:0] d, output logic [DATA_W-1:0] q);
    @(posedge clk) #1;
    p.cs_n = off;
    p.ctrl = c;
    p.wr_n = !w;
    p.rd_n = w;
    drv = d;
    repeat (8) @(posedge clk);
    #1 q = pins.data;
    p = PINS_IDLE;
    repeat (6) @(posedge clk);
  endtask
endmodule

//--- bench/timer_host_bus_port_bench.sv
`timescale 1ns/1ps
module timer_host_bus_port_bench;
  import tmhp_pkg::*;
  logic CLOCK = 1'b0;
  logic RST_N = 1'b0;
  logic [DATA_W-1:0] status = 16'h0000;
  tmhp_pins_s pins;
  logic [DATA_W-1:0] dout, oe_n, mm, q, v;
  logic [BYTE_W-1:0] cmd;
  logic [PTR_W-1:0] ptr, pt;
  logic [COUNTERS-1:0] gate_n;
  logic stb, bw;
  int n_errors = 0;
  int samples_checked = 0;
  int seed = 68;
  logic [DATA_W-1:0] mem [DEPTH];
  logic [PTR_W-1:0] pq [$];
  always #5 CLOCK = ~CLOCK;
  tmhp_host host (.clk(CLOCK), .dout(dout), .oe_n(oe_n), .pins(pins));
  tmhp_port uut (.CLOCK(CLOCK), .RST_N(RST_N), .CS_N(pins.cs_n),
    .RD_N(pins.rd_n), .WR_N(pins.wr_n), .CTRL_SEL(pins.ctrl),
    .HOST_DATA_LINES_IN(pins.data), .HOST_DATA_LINES_OUT(dout),
    .HOST_DATA_LINES_OE_N(oe_n), .STATUS(status), .COMMAND(cmd),
    .COMMAND_STROBE(stb), .DATA_POINTER(ptr), .MASTER_MODE(mm),
    .BUS_WIDTH_SELECT(bw), .AUX_GATE_ENABLE_N(gate_n));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic final_report;
    $display("checked %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic cw(input logic [BYTE_W-1:0] b);
    host.acc(1'b0, 1'b1, 1'b1, {8'h00, b}, q);
  endtask
  initial begin
    repeat (5000) @(posedge CLOCK);
    n_errors++;
    final_report;
  end
  initial begin
    repeat (5) @(posedge CLOCK);
    #1 RST_N = 1'b1;
    status = DATA_W'($random(seed));
    host.gates = COUNTERS'($random(seed));
    host.acc(1'b0, 1'b1, 1'b0, 16'h0000, q);
    chk({8'h00, q[7:0]}, {8'h00, status[7:0]});
    chk({11'h0, gate_n}, {11'h0, host.gates});
    chk({11'h0, ptr}, {11'h0, PTR_RESET});
    chk({15'h0000, bw}, 16'h0000);
    $display("status test done");
    repeat (4) begin
      pt = PTR_W'($unsigned($random(seed)) % 23);
      v = DATA_W'($random(seed));
      mem[pt] = v;
      pq.push_back(pt);
      cw({3'h0, pt});
      chk({11'h0, ptr}, {11'h0, pt});
      host.acc(1'b0, 1'b0, 1'b1, {8'h00, v[7:0]}, q);
      host.acc(1'b0, 1'b0, 1'b1, {8'h00, v[15:8]}, q);
    end
    foreach (pq[i]) begin
      cw({3'h0, pq[i]});
      host.acc(1'b0, 1'b0, 1'b0, 16'h0000, q);
      v[7:0] = q[7:0];
      host.acc(1'b0, 1'b0, 1'b0, 16'h0000, q);
      chk({q[7:0], v[7:0]}, mem[pq[i]]);
    end
    cw(8'hE5);
    chk({8'h00, cmd}, 16'h00E5);
    chk({11'h0, ptr}, {11'h0, pq[3]});
    host.acc(1'b1, 1'b1, 1'b1, 16'h003C, q);
    chk({8'h00, cmd}, 16'h00E5);
    $display("narrow test done");
    cw(8'h17);
    host.acc(1'b0, 1'b0, 1'b1, 16'h0000, q);
    host.acc(1'b0, 1'b0, 1'b1, 16'h0040, q);
    host.wide = 1'b1;
    chk(mm, 16'h4000);
    chk({11'h0, gate_n}, {11'h0, GATES_ENABLED});
    v = DATA_W'($random(seed));
    cw(8'h0A);
    host.acc(1'b0, 1'b0, 1'b1, v, q);
    host.acc(1'b0, 1'b0, 1'b0, 16'h0000, q);
    chk(q, v);
    host.acc(1'b0, 1'b1, 1'b0, 16'h0000, q);
    chk(q, status);
    $display("wide test done");
    final_report;
  end
endmodule
